// ### dv/fdsd_drive_model.sv
// Far-side model: up to four drives on the select, motor and rate lines.
// Assumes the block's pins are wired straight in, one clock domain.
`timescale 1ns/1ns
module fdsd_drive_model (
   input  wire logic [3:0] sel_n_in,
   input  wire logic [3:0] mtr_n_in,
   input  wire logic       rate_lo_in,
   input  wire logic       rate_lo_oe_in,
   input  wire logic       rate_hi_in,
   input  wire logic       rate_hi_oe_in,
   input  wire logic       lvl_lo_in,
   input  wire logic       lvl_hi_in,
   output logic            rate_lo_out,
   output logic            rate_hi_out,
   output logic [2:0]      n_sel_out,
   output logic [3:0]      spin_out
);
   // ==========================================================
   // Rate lines
   // Drives strap the rate lines only once the block lets go of them
   assign rate_lo_out = rate_lo_oe_in ? rate_lo_in : lvl_lo_in;
   assign rate_hi_out = rate_hi_oe_in ? rate_hi_in : lvl_hi_in;
   // ==========================================================
   // Drive activity
   assign n_sel_out   = 3'($countones(~sel_n_in));
   assign spin_out    = ~mtr_n_in;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the drive-select block.
// Assumes the design files and the drive model are compiled first.
`timescale 1ns/1ns
`include "fdsd_cfg.svh"
module testbench;
   logic                 clk_in;
   logic                 rst_n_in;
   logic [9:0]           addr_in;
   logic [7:0]           wdata_in;
   logic                 wr_in;
   logic                 rd_in;
   logic [1:0]           rate_sel_in;
   logic                 lvl_lo, lvl_hi, rl_w, rh_w;
   logic                 rl_o, rl_oe, rh_o, rh_oe, swr, dma;
   logic [7:0]           rdata, rdoe;
   logic [3:0]           sel_n, mtr_n, spin, m;
   logic [2:0]           n_sel;
   fdsd_pkg::fdsd_byte_t d, oe, cr6, e;
   int                   miscompares, n_checks;

   fdsd_top fdsd_top_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rate_sel_in(rate_sel_in), .rate_pin_lo_in(rl_w),
      .rate_pin_hi_in(rh_w), .rdata_out(rdata), .rdata_oe_out(rdoe),
      .rate_pin_lo_out(rl_o), .rate_pin_lo_oe_out(rl_oe),
      .rate_pin_hi_out(rh_o), .rate_pin_hi_oe_out(rh_oe),
      .drive_sel0_n_out(sel_n[0]), .drive_sel1_n_out(sel_n[1]),
      .drive_sel2_n_out(sel_n[2]), .drive_sel3_n_out(sel_n[3]),
      .motor_on0_n_out(mtr_n[0]), .motor_on1_n_out(mtr_n[1]),
      .motor_on2_n_out(mtr_n[2]), .motor_on3_n_out(mtr_n[3]),
      .fdc_soft_reset_out(swr), .dma_enable_out(dma));

   fdsd_drive_model fdsd_drive_model_inst (
      .sel_n_in(sel_n), .mtr_n_in(mtr_n), .rate_lo_in(rl_o),
      .rate_lo_oe_in(rl_oe), .rate_hi_in(rh_o), .rate_hi_oe_in(rh_oe),
      .lvl_lo_in(lvl_lo), .lvl_hi_in(lvl_hi), .rate_lo_out(rl_w),
      .rate_hi_out(rh_w), .n_sel_out(n_sel), .spin_out(spin));

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end
   // About 360 cycles of tests; the limit leaves ample margin
   initial begin
      #(3000 * 100);
      miscompares++;
      give_verdict;
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input fdsd_pkg::fdsd_byte_t seen,
                      input fdsd_pkg::fdsd_byte_t exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] v);
      @(posedge clk_in);
      wr_in <= 1'h1;
      addr_in <= a;
      wdata_in <= v;
      @(posedge clk_in);
      wr_in <= 1'h0;
   endtask
   task automatic rd_reg(input logic [9:0] a);
      @(posedge clk_in);
      rd_in <= 1'h1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'h0;
      #1;
      d = rdata;
      oe = rdoe;
   endtask
   // Pins follow the register one edge after it updates
   task automatic settle;
      repeat (2) @(posedge clk_in);
      #1;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic fdsd_pkg::fdsd_byte_t exp_pins(input logic [1:0] v,
      input logic [1:0] c, input logic [3:0] m);
      logic [1:0] s;
      logic [3:0] sel;
      logic [3:0] mt;
      s = (c[1] == 1'h0) ? (c ^ 2'h1) : c;
      mt = ~m;
      sel = m[c] ? ~(4'h1 << ((v == 2'h1) ? s : c)) : 4'hF;
      if (v == 2'h1) begin
         mt = {~m[3], ~m[2], ~m[0], ~m[1]};
      end
      if (v[1]) begin
         sel = {2'h3, (v[0] ? s : c)};
         mt = {3'h7, ~m[c]};
      end
      return {mt, sel};
   endfunction

   // ==========================================================
   // Tests
   initial begin
      rst_n_in = 1'h0;
      addr_in = 10'h000;
      wdata_in = 8'h00;
      wr_in = 1'h0;
      rd_in = 1'h0;
      rate_sel_in = 2'h2;
      lvl_lo = 1'h0;
      lvl_hi = 1'h0;
      cr6 = 8'h1B;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'h1;
      #1;
      chk("pins_rst", {mtr_n, sel_n}, 8'hFF);
      chk("swr_rst", swr, 8'h01);
      chk("dma_rst", dma, 8'h00);
      for (int t = 0; t < 4; t++) begin
         wr_reg(`FDSD_ADDR_TAPE, {6'h3F, 2'(t)});
         rd_reg(`FDSD_ADDR_TAPE);
         chk("tape_d", d, 8'(t));
         chk("tape_oe", oe, 8'h03);
      end
      chk("rate_out", {4'h0, rl_oe, rh_oe, rl_o, rh_o}, 8'h0D);
      wr_reg(10'h3F0, 8'h55);
      rd_reg(10'h3F0);
      chk("unmap_oe", oe, 8'h00);
      chk("unmap_d", d, 8'h00);
      // Soft reset and DMA enable through the control register
      wr_reg(`FDSD_ADDR_TAPE, 8'h02);
      wr_reg(`FDSD_ADDR_DOC, 8'h08);
      settle;
      chk("swr_on", swr, 8'h01);
      chk("dma_on", dma, 8'h01);
      wr_reg(`FDSD_ADDR_DOC, 8'h04);
      rd_reg(`FDSD_ADDR_TAPE);
      chk("tape_keep", d, 8'h02);
      rd_reg(`FDSD_ADDR_DOC);
      chk("doc_rb", d, 8'h04);
      chk("swr_off", swr, 8'h00);
      // All variants, codes, coded motor bit set, clear, all clear
      for (int v = 0; v < 4; v++) begin
         wr_reg(`FDSD_ADDR_MODE, {6'h00, 2'(v)});
         for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 3; k++) begin
               m = (k == 0) ? (4'h1 << c) : (k == 1) ? ~(4'h1 << c) : 4'h0;
               wr_reg(`FDSD_ADDR_TAPE, 8'(c ^ 3));
               wr_reg(`FDSD_ADDR_DOC, {m, 2'h1, 2'(c)});
               settle;
               e = exp_pins(2'(v), 2'(c), m);
               chk("pins", {mtr_n, sel_n}, e);
               if (v == 0) begin
                  chk("spin", 8'(spin), 8'(m));
               end
               if (v < 2) begin
                  chk("one_sel", 8'(n_sel), (k == 0) ? 8'h01 : 8'h00);
               end
            end
         end
      end
      // Enhanced mode 2 readback with the drives strapping rate lines
      wr_reg(`FDSD_ADDR_CR6, cr6);
      wr_reg(`FDSD_ADDR_CR7, 8'hFE);
      wr_reg(`FDSD_ADDR_TAPE, 8'h01);
      wr_reg(`FDSD_ADDR_MODE, 8'h04);
      for (int c = 0; c < 4; c++) begin
         lvl_lo <= c[0];
         lvl_hi <= c[1];
         wr_reg(`FDSD_ADDR_DOC, 8'(8'h04 | c));
         rd_reg(`FDSD_ADDR_TAPE);
         e = {c[1], c[0], cr6[2*c+1 -: 2], 2'h2, 2'h1};
         chk("os2_d", d, e);
         chk("os2_oe", oe, 8'hFF);
      end
      rd_reg(`FDSD_ADDR_CR6);
      chk("cr6_rb", d, cr6);
      rd_reg(`FDSD_ADDR_CR7);
      chk("cr7_rb", d, 8'hFE);
      rd_reg(`FDSD_ADDR_MODE);
      chk("mode_rb", d, 8'h04);
      chk("rate_oe", {rl_oe, rh_oe}, 8'h00);
      give_verdict;
   end
endmodule

// ### rtl/fdsd_cfg.svh
// Addresses, field positions and reset values of the drive-select block.
// Assumes inclusion by bare name from the design files.
`ifndef FDSD_CFG_SVH
`define FDSD_CFG_SVH
// ==========================================================
// Register addresses
`define FDSD_ADDR_DOC   10'h3F2
`define FDSD_ADDR_TAPE  10'h3F3
`define FDSD_ADDR_CR6   10'h3E6
`define FDSD_ADDR_CR7   10'h3E7
`define FDSD_ADDR_MODE  10'h3E8
// ==========================================================
// Field positions
`define FDSD_DOC_CODE   1:0
`define FDSD_DOC_NRST   2
`define FDSD_DOC_DMAEN  3
`define FDSD_DOC_MTR    7:4
`define FDSD_TAPE_FLD   1:0
`define FDSD_TYPE_FLD   5:4
`define FDSD_BOOT_FLD   3:2
`define FDSD_RATE_LO    6
`define FDSD_RATE_HI    7
`define FDSD_CR7_BOOT   1:0
`define FDSD_MODE_VAR   1:0
`define FDSD_MODE_OS2   2
`define FDSD_MODE_FLD   2:0
// ==========================================================
// Reset values and read enables
`define FDSD_DOC_RST    8'h00
`define FDSD_TAPE_RST   2'h0
`define FDSD_CR_RST     8'h00
`define FDSD_MODE_RST   3'h0
`define FDSD_SEL_IDLE   4'hF
`define FDSD_OE_NONE    8'h00
`define FDSD_OE_ALL     8'hFF
`define FDSD_OE_TAPE    8'h03
`endif

// ### rtl/fdsd_dec_if.sv
// Carrier between the register bank and the select decoder.
// Assumes both ends share one clock domain.
`timescale 1ns/1ns
interface fdsd_dec_if;
   fdsd_pkg::fdsd_byte_t    doc;
   fdsd_pkg::fdsd_variant_e variant;
   logic [3:0]              sel_n;
   logic [3:0]              mtr_n;
   modport ctl (output doc, output variant, input sel_n, input mtr_n);
   modport dec (input doc, input variant, output sel_n, output mtr_n);
endinterface

// ### rtl/fdsd_decode.sv
// Combinational drive-select and motor decode for four variants.
// Assumes the caller registers the outputs before the pins.
`timescale 1ns/1ns
`include "fdsd_cfg.svh"
module fdsd_decode (
   fdsd_dec_if.dec dif
);
   logic [1:0] code;
   logic [1:0] phys;
   logic [3:0] mtr;
   logic       en;

   // ==========================================================
   // Decode
   always_comb begin
      code = dif.doc[`FDSD_DOC_CODE];
      mtr  = dif.doc[`FDSD_DOC_MTR];
      en   = mtr[code];
      // Swap only trades drives 0 and 1; codes 2 and 3 pass
      phys = code[1] ? code : {code[1], ~code[0]};
      unique case (dif.variant)
         fdsd_pkg::fdsd_int_norm: begin
            dif.sel_n = en ? ~(4'h1 << code) : `FDSD_SEL_IDLE;
            dif.mtr_n = ~mtr;
         end
         fdsd_pkg::fdsd_int_swap: begin
            dif.sel_n = en ? ~(4'h1 << phys) : `FDSD_SEL_IDLE;
            dif.mtr_n = {~mtr[3], ~mtr[2], ~mtr[0], ~mtr[1]};
         end
         fdsd_pkg::fdsd_ext_norm: begin
            dif.sel_n = {2'h3, code};
            dif.mtr_n = {3'h7, ~en};
         end
         fdsd_pkg::fdsd_ext_swap: begin
            dif.sel_n = {2'h3, phys};
            dif.mtr_n = {3'h7, ~en};
         end
      endcase
   end
endmodule

// ### rtl/fdsd_pkg.sv
// Types shared by the drive-select block.
// Assumes nothing of its surroundings.
package fdsd_pkg;
   // ==========================================================
   // Decode variant, order matches the mode register field
   typedef enum logic [1:0] {
      fdsd_int_norm,
      fdsd_int_swap,
      fdsd_ext_norm,
      fdsd_ext_swap
   } fdsd_variant_e;
   typedef logic [7:0] fdsd_byte_t;
endpackage

// ### rtl/fdsd_top.sv
// Floppy drive-select decode with drive output control, tape select,
// and the two configuration registers it reads back.
// Assumes a single clock and a host port that never waits.
//
// Functional notes
// - Tape-select register at 3F3 is read/write and steers no logic.
// - Software reset leaves the tape-select register unchanged.
// - Normal mode: only bits 1:0 exist, bits 7:2 undriven on read.
// - Tape code 0 selects none, 1, 2, 3 select tape drives 1-3.
// - Internal normal: select numbered by code low when its motor bit set.
// - Internal normal: motor outputs are inverted bits 4 to 7.
// - Internal swapped: drives 0 and 1 trade selects and motors.
// - External normal: selects carry the code, motor 1 held high.
// - External: motor 0 low only when coded drive's motor bit set.
// - External swapped: codes 00 and 01 trade, others pass.
// - Enhanced mode 2 read: rate pins, type id, boot drive, tape bits.
// - Enhanced mode 2: rate pins are inputs read into bits 6 and 7.
// - Type id is the config six pair picked by last drive code.
// - Boot drive field is config seven bits 1 and 0.
// - Drive code is binary, so in the internal variants at most one select is active.
`timescale 1ns/1ns
`include "fdsd_cfg.svh"
module fdsd_top #(
   parameter int AW = 10
) (
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [7:0]    wdata_in,
   input  wire logic          wr_in,
   input  wire logic          rd_in,
   input  wire logic [1:0]    rate_sel_in,
   input  wire logic          rate_pin_lo_in,
   input  wire logic          rate_pin_hi_in,
   output logic [7:0]         rdata_out,
   output logic [7:0]         rdata_oe_out,
   output logic               rate_pin_lo_out,
   output logic               rate_pin_lo_oe_out,
   output logic               rate_pin_hi_out,
   output logic               rate_pin_hi_oe_out,
   output logic               drive_sel0_n_out,
   output logic               drive_sel1_n_out,
   output logic               drive_sel2_n_out,
   output logic               drive_sel3_n_out,
   output logic               motor_on0_n_out,
   output logic               motor_on1_n_out,
   output logic               motor_on2_n_out,
   output logic               motor_on3_n_out,
   output logic               fdc_soft_reset_out,
   output logic               dma_enable_out
);
   // ==========================================================
   // Storage
   fdsd_pkg::fdsd_byte_t drive_output_control;
   logic [1:0]           tape_select_reg;
   fdsd_pkg::fdsd_byte_t config_reg_six;
   fdsd_pkg::fdsd_byte_t config_reg_seven;
   logic [2:0]           mode_reg;
   logic [3:0]           sel_q;
   logic [3:0]           mtr_q;

   // ==========================================================
   // Decodes of the host port
   logic       hit_doc;
   logic       hit_tape;
   logic       hit_cr6;
   logic       hit_cr7;
   logic       hit_mode;
   logic       enhanced_mode_two;
   logic [1:0] doc_code;
   logic [3:0] doc_mtr;
   logic [7:0] type_shift;
   logic [1:0] type_pair;
   logic [7:0] next_rdata;
   logic [7:0] next_oe;

   assign hit_doc           = (addr_in == `FDSD_ADDR_DOC);
   assign hit_tape          = (addr_in == `FDSD_ADDR_TAPE);
   assign hit_cr6           = (addr_in == `FDSD_ADDR_CR6);
   assign hit_cr7           = (addr_in == `FDSD_ADDR_CR7);
   assign hit_mode          = (addr_in == `FDSD_ADDR_MODE);
   assign enhanced_mode_two = mode_reg[`FDSD_MODE_OS2];
   assign doc_code          = drive_output_control[`FDSD_DOC_CODE];
   assign doc_mtr           = drive_output_control[`FDSD_DOC_MTR];

   // ==========================================================
   // Decoder
   fdsd_dec_if dif ();
   assign dif.doc     = drive_output_control;
   assign dif.variant =
      fdsd_pkg::fdsd_variant_e'(mode_reg[`FDSD_MODE_VAR]);
   fdsd_decode u_decode (
      .dif (dif.dec)
   );

   // ==========================================================
   // Drive output control; a software reset never clears it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         drive_output_control <= `FDSD_DOC_RST;
      end else if (wr_in && hit_doc) begin
         drive_output_control <= wdata_in;
      end
   end

   // ==========================================================
   // Tape select, only hardware reset clears it
   // Its code is a software meaning only; only the read path reads it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tape_select_reg <= `FDSD_TAPE_RST;
      end else if (wr_in && hit_tape) begin
         tape_select_reg <= wdata_in[`FDSD_TAPE_FLD];
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         config_reg_six <= `FDSD_CR_RST;
      end else if (wr_in && hit_cr6) begin
         config_reg_six <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         config_reg_seven <= `FDSD_CR_RST;
      end else if (wr_in && hit_cr7) begin
         config_reg_seven <= wdata_in;
      end
   end

   // Changing the variant while drives run remaps the select pins on the edge after mode_reg loads
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_reg <= `FDSD_MODE_RST;
      end else if (wr_in && hit_mode) begin
         mode_reg <= wdata_in[`FDSD_MODE_FLD];
      end
   end

   // ==========================================================
   // Read path
   always_comb begin
      type_shift = config_reg_six >> {doc_code, 1'b0};
      type_pair  = type_shift[1:0];
      next_rdata = `FDSD_OE_NONE;
      next_oe    = `FDSD_OE_NONE;
      if (rd_in) begin
         if (hit_doc) begin
            next_rdata = drive_output_control;
            next_oe    = `FDSD_OE_ALL;
         end else if (hit_tape && enhanced_mode_two) begin
            next_rdata[`FDSD_RATE_HI]  = rate_pin_hi_in;
            next_rdata[`FDSD_RATE_LO]  = rate_pin_lo_in;
            next_rdata[`FDSD_TYPE_FLD] = type_pair;
            next_rdata[`FDSD_BOOT_FLD] =
               config_reg_seven[`FDSD_CR7_BOOT];
            next_rdata[`FDSD_TAPE_FLD] = tape_select_reg;
            next_oe    = `FDSD_OE_ALL;
         end else if (hit_tape) begin
            next_rdata[`FDSD_TAPE_FLD] = tape_select_reg;
            next_oe    = `FDSD_OE_TAPE;
         end else if (hit_cr6) begin
            next_rdata = config_reg_six;
            next_oe    = `FDSD_OE_ALL;
         end else if (hit_cr7) begin
            next_rdata = config_reg_seven;
            next_oe    = `FDSD_OE_ALL;
         end else if (hit_mode) begin
            next_rdata[`FDSD_MODE_FLD] = mode_reg;
            next_oe    = `FDSD_OE_ALL;
         end
      end
   end

   // Unmapped reads leave the bus undriven for other decoders
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_out    <= `FDSD_OE_NONE;
         rdata_oe_out <= `FDSD_OE_NONE;
      end else begin
         rdata_out    <= next_rdata;
         rdata_oe_out <= next_oe;
      end
   end

   // ==========================================================
   // Drive pins, registered to keep decode glitches off the cable
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sel_q <= `FDSD_SEL_IDLE;
         mtr_q <= `FDSD_SEL_IDLE;
      end else begin
         sel_q <= dif.sel_n;
         mtr_q <= dif.mtr_n;
      end
   end

   assign drive_sel0_n_out = sel_q[0];
   assign drive_sel1_n_out = sel_q[1];
   assign drive_sel2_n_out = sel_q[2];
   assign drive_sel3_n_out = sel_q[3];
   assign motor_on0_n_out  = mtr_q[0];
   assign motor_on1_n_out  = mtr_q[1];
   assign motor_on2_n_out  = mtr_q[2];
   assign motor_on3_n_out  = mtr_q[3];

   // ==========================================================
   // Rate pins and controller side outputs
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rate_pin_lo_out    <= 1'b0;
         rate_pin_hi_out    <= 1'b0;
         rate_pin_lo_oe_out <= 1'b0;
         rate_pin_hi_oe_out <= 1'b0;
      end else begin
         rate_pin_lo_out    <= rate_sel_in[0];
         rate_pin_hi_out    <= rate_sel_in[1];
         rate_pin_lo_oe_out <= !enhanced_mode_two;
         rate_pin_hi_oe_out <= !enhanced_mode_two;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fdc_soft_reset_out <= 1'b1;
         dma_enable_out     <= 1'b0;
      end else begin
         fdc_soft_reset_out <= !drive_output_control[`FDSD_DOC_NRST];
         dma_enable_out     <= drive_output_control[`FDSD_DOC_DMAEN];
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence seq_tape_read;
      rd_in && hit_tape;
   endsequence

   sequence seq_os2_read;
      seq_tape_read ##0 enhanced_mode_two;
   endsequence

   sequence seq_normal_read;
      seq_tape_read ##0 !enhanced_mode_two;
   endsequence

   tape_read_a: assert property (
      seq_tape_read |=> rdata_oe_out[1:0] == 2'h3 &&
         rdata_out[1:0] == $past(tape_select_reg))
      else $error("tape bits not returned");

   tape_hold_a: assert property (
      !(wr_in && hit_tape) |=> $stable(tape_select_reg))
      else $error("tape select changed without a write");

   tri_normal_a: assert property (
      seq_normal_read |=> rdata_oe_out == `FDSD_OE_TAPE)
      else $error("upper tape bits driven in normal mode");

   int_sel_a: assert property (
      dif.variant == fdsd_pkg::fdsd_int_norm && doc_mtr[doc_code]
      |=> sel_q == ~(4'h1 << $past(doc_code)))
      else $error("internal select wrong");

   int_motor_a: assert property (
      dif.variant == fdsd_pkg::fdsd_int_norm |=> mtr_q == ~$past(doc_mtr))
      else $error("internal motors wrong");

   swap_sel_a: assert property (
      dif.variant == fdsd_pkg::fdsd_int_swap && doc_code == 2'h0 &&
      doc_mtr[0] |=> sel_q == 4'hD && mtr_q[1] == 1'b0)
      else $error("swapped drive 0 not on select 1");

   ext_sel_a: assert property (
      dif.variant == fdsd_pkg::fdsd_ext_norm
      |=> sel_q[1:0] == $past(doc_code) && mtr_q[1] && sel_q[3:2] == 2'h3)
      else $error("external select wrong");

   ext_motor_a: assert property (
      dif.variant inside {fdsd_pkg::fdsd_ext_norm, fdsd_pkg::fdsd_ext_swap}
      |=> mtr_q[0] == !$past(doc_mtr[doc_code]))
      else $error("external motor wrong");

   ext_swap_a: assert property (
      dif.variant == fdsd_pkg::fdsd_ext_swap
      |=> sel_q[1:0] == ($past(doc_code[1]) ? $past(doc_code)
                         : {1'b0, !$past(doc_code[0])}))
      else $error("external swap wrong");

   os2_read_a: assert property (
      seq_os2_read |=> rdata_oe_out == `FDSD_OE_ALL &&
         rdata_out[7] == $past(rate_pin_hi_in) &&
         rdata_out[6] == $past(rate_pin_lo_in) &&
         rdata_out[5] == $past(config_reg_six[{doc_code, 1'b1}]) &&
         rdata_out[4] == $past(config_reg_six[{doc_code, 1'b0}]) &&
         rdata_out[3:2] == $past(config_reg_seven[1:0]))
      else $error("enhanced tape read layout wrong");

   // Internal only: external selects carry the binary code itself
   one_sel_a: assert property (
      !mode_reg[1] |=> $countones(~sel_q) <= 1)
      else $error("more than one select active");

   mode_hold_a: assert property (
      !(wr_in && hit_mode) |=> $stable(mode_reg))
      else $error("variant changed without a write");

   idle_sel_a: assert property (
      !mode_reg[1] && !doc_mtr[doc_code] |=> sel_q == `FDSD_SEL_IDLE)
      else $error("select active with motor bit clear");

   swap_sel1_a: assert property (
      dif.variant == fdsd_pkg::fdsd_int_swap && doc_code == 2'h1 &&
      doc_mtr[1] |=> sel_q == 4'hE && mtr_q[0] == 1'h0)
      else $error("swapped drive 1 not on select 0");

   swap_motor_a: assert property (
      dif.variant == fdsd_pkg::fdsd_int_swap |=> mtr_q ==
         {~$past(doc_mtr[3:2]), ~$past(doc_mtr[0]), ~$past(doc_mtr[1])})
      else $error("swapped motors wrong");

   ext_idle_a: assert property (
      mode_reg[1] |=> sel_q[3:2] == 2'h3 && mtr_q[3:1] == 3'h7)
      else $error("external unused pins not idle");

   rate_in_a: assert property (
      enhanced_mode_two |=> !rate_pin_lo_oe_out && !rate_pin_hi_oe_out)
      else $error("rate pins driven in enhanced mode 2");

   tape_write_a: assert property (
      wr_in && hit_tape |=> tape_select_reg == $past(wdata_in[1:0]))
      else $error("tape write lost");

   tape_upper_a: assert property (
      seq_normal_read |=> rdata_out[7:2] == 6'h00)
      else $error("upper tape bits not quiet");

endmodule
